/* File: verilog/boa_defines.vh */
// constants of the byte-operation alu: opcodes, flag positions, register indices, reset values
`ifndef BOA_DEFINES_VH
`define BOA_DEFINES_VH

// -----------------------------------------------------------------
// instruction fields
// -----------------------------------------------------------------
`define BOA_OP_HI          13
`define BOA_OP_LO          8
`define BOA_DEST_BIT       7
`define BOA_FADR_HI        6

// -----------------------------------------------------------------
// upper six opcode bits
// -----------------------------------------------------------------
`define BOA_OP_ADD         6'h07
`define BOA_OP_ADDC        6'h3D
`define BOA_OP_AND         6'h05
`define BOA_OP_ASR         6'h37
`define BOA_OP_LSL         6'h35
`define BOA_OP_LSR         6'h36
`define BOA_OP_CLR         6'h01
`define BOA_OP_COM         6'h09
`define BOA_OP_DEC         6'h03
`define BOA_OP_INC         6'h0A
`define BOA_OP_RLC         6'h0D
`define BOA_OP_RRC         6'h0C

// -----------------------------------------------------------------
// flag register layout
// -----------------------------------------------------------------
`define BOA_FLG_C          0
`define BOA_FLG_DC         1
`define BOA_FLG_Z          2
`define BOA_FLG_SLEEP      3
`define BOA_FLG_WDOG       4
`define BOA_FLG_WR_MASK    8'h07

// -----------------------------------------------------------------
// register indices, byte address is four times the index
// -----------------------------------------------------------------
`define BOA_IDX_FLAGS      7'h03
`define BOA_IDX_ACC        7'h09

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define BOA_RST_FLAGS      8'h18
`define BOA_RST_ACC        8'h00
`define BOA_RST_FILE       8'h00

`endif

/* File: verilog/boa_alu_core.v */
// combinational result and flag logic of the byte operations
`timescale 1ns/1ps
`include "boa_defines.vh"
module boa_alu_core (
   input  wire [5:0] op,
   input  wire       dest,
   input  wire [6:0] fadr,
   input  wire [7:0] acc,
   input  wire [7:0] fval,
   input  wire       cin,
   output reg  [7:0] res,
   output reg        c_out,
   output reg        dc_out,
   output wire       z_out,
   output reg        upd_c,
   output reg        upd_dc,
   output reg        upd_z,
   output reg        known,
   output reg        to_acc
);

   reg [8:0] sum;
   reg [4:0] nib;

   assign z_out = (res == 8'h00);

   always @* begin
      sum    = 9'h000;
      nib    = 5'h00;
      res    = 8'h00;
      c_out  = cin;
      dc_out = 1'b0;
      upd_c  = 1'b0;
      upd_dc = 1'b0;
      upd_z  = 1'b0;
      known  = 1'b1;
      to_acc = ~dest;
      case (op)
         `BOA_OP_ADD, `BOA_OP_ADDC: begin
            sum    = {1'b0, acc} + {1'b0, fval} + {8'h00, (op == `BOA_OP_ADDC) & cin};
            nib    = {1'b0, acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, (op == `BOA_OP_ADDC) & cin};
            res    = sum[7:0];
            c_out  = sum[8];
            dc_out = nib[4];
            upd_c  = 1'b1;
            upd_dc = 1'b1;
            upd_z  = 1'b1;
         end
         `BOA_OP_AND: begin
            res   = acc & fval;
            upd_z = 1'b1;
         end
         `BOA_OP_ASR: begin
            res   = {fval[7], fval[7:1]};
            c_out = fval[0];
            upd_c = 1'b1;
            upd_z = 1'b1;
         end
         `BOA_OP_LSL: begin
            res   = {fval[6:0], 1'b0};
            c_out = fval[7];
            upd_c = 1'b1;
            upd_z = 1'b1;
         end
         `BOA_OP_LSR: begin
            res   = {1'b0, fval[7:1]};
            c_out = fval[0];
            upd_c = 1'b1;
            upd_z = 1'b1;
         end
         `BOA_OP_CLR: begin
            res   = 8'h00;
            upd_z = 1'b1;
            // the accumulator form needs address bits 6:2 clear
            known = dest | (fadr[6:2] == 5'h00);
         end
         `BOA_OP_COM: begin
            res   = ~fval;
            upd_z = 1'b1;
         end
         `BOA_OP_DEC: begin
            res   = fval - 8'h01;
            upd_z = 1'b1;
         end
         `BOA_OP_INC: begin
            res   = fval + 8'h01;
            upd_z = 1'b1;
         end
         `BOA_OP_RLC: begin
            res   = {fval[6:0], cin};
            c_out = fval[7];
            upd_c = 1'b1;
         end
         `BOA_OP_RRC: begin
            res   = {cin, fval[7:1]};
            c_out = fval[0];
            upd_c = 1'b1;
         end
         default: begin
            known = 1'b0;
         end
      endcase
   end

endmodule

/* File: verilog/boa_file_ram.v */
// flip-flop file register storage, one write port and two read ports
`timescale 1ns/1ps
`include "boa_defines.vh"
module boa_file_ram #(
   parameter AW    = 7,
   parameter DW    = 8,
   parameter DEPTH = 128
) (
   input  wire          sys_clk,
   input  wire          nrst,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_adr,
   input  wire [DW-1:0] wr_dat,
   input  wire [AW-1:0] rd_a_adr,
   output wire [DW-1:0] rd_a_dat,
   input  wire [AW-1:0] rd_b_adr,
   output wire [DW-1:0] rd_b_dat
);

   reg [DW-1:0] mem_ff [0:DEPTH-1];
   integer      i;

   assign rd_a_dat = mem_ff[rd_a_adr];
   assign rd_b_dat = mem_ff[rd_b_adr];

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_ff[i] <= {DW{1'b0}};
         end
      end else if (wr_en) begin
         mem_ff[wr_adr] <= wr_dat;
      end
   end

endmodule

/* File: verilog/boa_alu_top.v */
// byte-operation decode and datapath with file registers behind a wishbone slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "boa_defines.vh"
module boa_alu_top (
   input  wire        sys_clk,
   input  wire        nrst,
   // instruction port, one instruction per cycle
   input  wire        instr_valid,
   input  wire [13:0] instr,
   output reg         instr_done_ff,
   output reg         instr_bad_ff,
   output reg  [7:0]  acc_out_ff,
   output reg  [7:0]  flags_out_ff,
   // classic wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [8:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg  [7:0] acc_ff;
   reg  [7:0] flags_ff;
   reg  [7:0] nxt_acc;
   reg  [7:0] nxt_flags;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire [5:0] op   = instr[`BOA_OP_HI:`BOA_OP_LO];
   wire       dest = instr[`BOA_DEST_BIT];
   wire [6:0] fadr = instr[`BOA_FADR_HI:0];

   wire [7:0] ram_a_dat;
   wire [7:0] ram_b_dat;
   reg  [7:0] fval;

   // special registers overlay the storage
   always @* begin
      if (fadr == `BOA_IDX_FLAGS) begin
         fval = flags_ff;
      end else if (fadr == `BOA_IDX_ACC) begin
         fval = acc_ff;
      end else begin
         fval = ram_a_dat;
      end
   end

   // -----------------------------------------------------------------
   // datapath
   // -----------------------------------------------------------------
   wire [7:0] res;
   wire       c_n;
   wire       dc_n;
   wire       z_n;
   wire       upd_c;
   wire       upd_dc;
   wire       upd_z;
   wire       known;
   wire       to_acc;

   boa_alu_core u_core (
      .op     (op),
      .dest   (dest),
      .fadr   (fadr),
      .acc    (acc_ff),
      .fval   (fval),
      .cin    (flags_ff[`BOA_FLG_C]),
      .res    (res),
      .c_out  (c_n),
      .dc_out (dc_n),
      .z_out  (z_n),
      .upd_c  (upd_c),
      .upd_dc (upd_dc),
      .upd_z  (upd_z),
      .known  (known),
      .to_acc (to_acc)
   );

   wire exec      = instr_valid & known;
   wire wr_acc    = exec & to_acc;
   wire wr_file   = exec & ~to_acc;
   wire wr_fflags = wr_file & (fadr == `BOA_IDX_FLAGS);
   wire wr_facc   = wr_file & (fadr == `BOA_IDX_ACC);
   wire wr_fram   = wr_file & ~wr_fflags & ~wr_facc;

   // -----------------------------------------------------------------
   // wishbone slave
   // -----------------------------------------------------------------
   // the instruction port has priority; a bus access waits while it is busy
   wire [6:0] wb_idx   = wb_adr_i[8:2];
   wire       wb_take  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~instr_valid;
   wire       wb_wr    = wb_take & wb_we_i & wb_sel_i[0];
   wire       wb_wflg  = wb_wr & (wb_idx == `BOA_IDX_FLAGS);
   wire       wb_wacc  = wb_wr & (wb_idx == `BOA_IDX_ACC);
   wire       wb_wram  = wb_wr & ~wb_wflg & ~wb_wacc;
   reg  [7:0] wb_rd;

   always @* begin
      if (wb_idx == `BOA_IDX_FLAGS) begin
         wb_rd = flags_ff;
      end else if (wb_idx == `BOA_IDX_ACC) begin
         wb_rd = acc_ff;
      end else begin
         wb_rd = ram_b_dat;
      end
   end

   // -----------------------------------------------------------------
   // file register storage
   // -----------------------------------------------------------------
   boa_file_ram #(
      .AW    (7),
      .DW    (8),
      .DEPTH (128)
   ) u_ram (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .wr_en    (wr_fram | wb_wram),
      .wr_adr   (wr_fram ? fadr : wb_idx),
      .wr_dat   (wr_fram ? res : wb_dat_i[7:0]),
      .rd_a_adr (fadr),
      .rd_a_dat (ram_a_dat),
      .rd_b_adr (wb_idx),
      .rd_b_dat (ram_b_dat)
   );

   // -----------------------------------------------------------------
   // accumulator and flag next values
   // -----------------------------------------------------------------
   always @* begin
      nxt_acc = acc_ff;
      if (wr_acc | wr_facc) begin
         nxt_acc = res;
      end else if (wb_wacc) begin
         nxt_acc = wb_dat_i[7:0];
      end
   end

   // a result written to the flag register lands first, then affected flags override
   always @* begin
      nxt_flags = flags_ff;
      if (wr_fflags) begin
         nxt_flags = (flags_ff & ~`BOA_FLG_WR_MASK) | (res & `BOA_FLG_WR_MASK);
      end else if (wb_wflg) begin
         nxt_flags = (flags_ff & ~`BOA_FLG_WR_MASK) | (wb_dat_i[7:0] & `BOA_FLG_WR_MASK);
      end
      if (exec & upd_c) begin
         nxt_flags[`BOA_FLG_C] = c_n;
      end
      if (exec & upd_dc) begin
         nxt_flags[`BOA_FLG_DC] = dc_n;
      end
      if (exec & upd_z) begin
         nxt_flags[`BOA_FLG_Z] = z_n;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         acc_ff        <= `BOA_RST_ACC;
         flags_ff      <= `BOA_RST_FLAGS;
         acc_out_ff    <= `BOA_RST_ACC;
         flags_out_ff  <= `BOA_RST_FLAGS;
         instr_done_ff <= 1'b0;
         instr_bad_ff  <= 1'b0;
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h00000000;
      end else begin
         acc_ff        <= nxt_acc;
         flags_ff      <= nxt_flags;
         acc_out_ff    <= nxt_acc;
         flags_out_ff  <= nxt_flags;
         instr_done_ff <= exec;
         instr_bad_ff  <= instr_valid & ~known;
         wb_ack_o      <= wb_take;
         if (wb_take & ~wb_we_i) begin
            wb_dat_o <= {24'h000000, wb_rd};
         end
      end
   end

endmodule

/* File: bench/boa_alu_assertions.sv */
// port assertions and covers of the byte-operation alu
`timescale 1ns/1ps
module boa_alu_chk (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        instr_valid,
   input wire logic [13:0] instr,
   input wire logic        instr_done_ff,
   input wire logic        instr_bad_ff,
   input wire logic [7:0]  acc_out_ff,
   input wire logic [7:0]  flags_out_ff,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o
);
   wire [5:0] op   = instr[13:8];
   wire       nf3  = instr[6:0] != 7'h03;
   wire       calc = op inside {6'h07, 6'h3D, 6'h05, 6'h09, 6'h03, 6'h0A, 6'h37, 6'h35, 6'h36};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // -----------------------------------------------
   // instruction results
   // -----------------------------------------------
   chk_one_result: assert property (instr_valid |=> instr_done_ff ^ instr_bad_ff)
      else $error("no single result pulse");
   chk_quiet_idle: assert property (!instr_valid |=> !instr_done_ff && !instr_bad_ff)
      else $error("result pulse without instruction");
   chk_fixed_bits: assert property (flags_out_ff[7:3] == 5'h03)
      else $error("fixed flag bits moved");
   chk_clr_acc: assert property (instr_valid && instr[13:2] == 12'h040 |=> acc_out_ff == 8'h00 && flags_out_ff[2])
      else $error("accumulator not cleared");
   chk_clr_file: assert property (instr_valid && instr[13:7] == 7'h03 && instr[6:0] != 7'h09
      |=> acc_out_ff == $past(acc_out_ff) && flags_out_ff[2])
      else $error("file clear wrong");
   chk_and_keep: assert property (instr_valid && op == 6'h05 && nf3 |=> $stable(flags_out_ff[1:0]))
      else $error("and moved carry flags");
   chk_rot_keep_z: assert property (instr_valid && op[5:1] == 5'h06 && nf3 |=> $stable(flags_out_ff[2]))
      else $error("rotate moved zero flag");
   chk_z_tracks: assert property (instr_valid && !instr[7] && calc |=> flags_out_ff[2] == (acc_out_ff == 8'h00))
      else $error("zero flag off result");
   chk_dest_file: assert property (instr_valid && instr[7] && calc && instr[6:0] != 7'h09 |=> $stable(acc_out_ff))
      else $error("file result hit accumulator");
   // -----------------------------------------------
   // bus handshake
   // -----------------------------------------------
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !instr_valid |=> wb_ack_o)
      else $error("ack late");
   cov_addc: cover property (instr_valid && op == 6'h3D);
   cov_bad: cover property (instr_bad_ff);
   cov_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind boa_alu_top boa_alu_chk boa_alu_chk_i (.sys_clk(sys_clk), .nrst(nrst), .instr_valid(instr_valid),
   .instr(instr), .instr_done_ff(instr_done_ff), .instr_bad_ff(instr_bad_ff), .acc_out_ff(acc_out_ff),
   .flags_out_ff(flags_out_ff), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o));

/* File: bench/boa_alu_top_tb_top.sv */
// self-checking bench of the byte-operation alu
`timescale 1ns/1ps
module boa_alu_top_tb_top;
   reg         sys_clk     = 1'h0;
   reg         nrst        = 1'h0;
   reg         instr_valid = 1'h0;
   reg  [13:0] instr       = 14'h0000;
   reg         wb_cyc_i    = 1'h0;
   reg         wb_stb_i    = 1'h0;
   reg         wb_we_i     = 1'h0;
   reg  [8:0]  wb_adr_i    = 9'h000;
   reg  [3:0]  wb_sel_i    = 4'h0;
   reg  [31:0] wb_dat_i    = 32'h0;
   wire        instr_done_ff;
   wire        instr_bad_ff;
   wire [7:0]  acc_out_ff;
   wire [7:0]  flags_out_ff;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o;
   integer     n_mismatch  = 0;
   integer     checks      = 0;
   integer     seed        = 60117;
   integer     i;
   reg  [31:0] rv;
   reg  [6:0]  x;
   reg  [7:0]  mem [0:127];
   reg  [7:0]  acc         = 8'h00;
   reg  [2:0]  fl          = 3'h0;
   reg  [16:0] eq [$];
   reg  [7:0]  rq [$];
   reg  [5:0]  ops [0:11]  = '{6'h07, 6'h3D, 6'h05, 6'h37, 6'h35, 6'h36, 6'h01, 6'h09, 6'h03, 6'h0A, 6'h0D, 6'h0C};

   always #50 sys_clk = ~sys_clk;

   boa_alu_top boa_alu_top_i (.sys_clk(sys_clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
      .instr_done_ff(instr_done_ff), .instr_bad_ff(instr_bad_ff), .acc_out_ff(acc_out_ff),
      .flags_out_ff(flags_out_ff), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   // -----------------------------------------------
   // checking
   // -----------------------------------------------
   task cmp(input [31:0] g, input [31:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask

   task cmp_res(input [16:0] g, input [16:0] e);
      begin
         cmp({15'h0, g}, {15'h0, e});
      end
   endtask

   task cmp_rd(input [31:0] g, input [7:0] e);
      begin
         cmp(g, {24'h0, e});
      end
   endtask

   task wrap_up;
      begin
         if (eq.size() + rq.size() != 0) n_mismatch = n_mismatch + 1;
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   always @(negedge sys_clk) begin
      if ((instr_done_ff | instr_bad_ff) !== 1'b0) cmp_res({instr_bad_ff, acc_out_ff, flags_out_ff}, eq.pop_front());
      if ((wb_ack_o & !wb_we_i) !== 1'b0) cmp_rd(wb_dat_o, rq.pop_front());
   end

   // -----------------------------------------------
   // drivers with reference model
   // -----------------------------------------------
   task exe(input [13:0] w);
      reg [7:0] v;
      reg [7:0] r;
      reg       c;
      reg       h;
      reg       bad;
      begin
         v = mem[w[6:0]];
         c = fl[0];
         h = fl[1];
         r = 8'h00;
         bad = 1'b0;
         case (w[13:8])
            6'h07: begin h = acc[3:0] + v[3:0] > 15; {c, r} = acc + v; end
            6'h3D: begin h = acc[3:0] + v[3:0] + c > 15; {c, r} = acc + v + c; end
            6'h05: r = acc & v;
            6'h37: {r, c} = {v[7], v};
            6'h35: {c, r} = {v, 1'b0};
            6'h36: {r, c} = {1'b0, v};
            6'h01: bad = !w[7] && w[6:2] != 5'h00;
            6'h09: r = ~v;
            6'h03: r = v - 8'h01;
            6'h0A: r = v + 8'h01;
            6'h0D: {c, r} = {v, c};
            6'h0C: {r, c} = {c, v};
            default: bad = 1'b1;
         endcase
         if (!bad) begin
            fl = {w[13:9] == 5'h06 ? fl[2] : r == 8'h00, h, c};
            if (w[7]) mem[w[6:0]] = r;
            else acc = r;
         end
         eq.push_back({bad, acc, 3'h0, 2'h3, fl});
         @(posedge sys_clk);
         instr_valid <= 1'b1;
         instr <= w;
      end
   endtask

   task wb(input w, input [6:0] a, input [7:0] d, input s);
      integer k;
      begin
         if (w & s) begin
            if (a == 7'h03) fl = d[2:0];
            else if (a == 7'h09) acc = d;
            else mem[a] = d;
         end
         if (!w) rq.push_back(a == 7'h03 ? {5'h03, fl} : a == 7'h09 ? acc : mem[a]);
         @(posedge sys_clk);
         instr_valid <= 1'b0;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= {a, 2'h0};
         wb_sel_i <= {3'h7, s};
         wb_dat_i <= {24'h0, d};
         k = 0;
         do begin @(negedge sys_clk); k = k + 1; end while (wb_ack_o !== 1'b1 && k < 20);
         if (k == 20) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
         end
         @(posedge sys_clk);
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask

   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   initial begin
      #1000000;
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end

   initial begin
      for (i = 0; i < 128; i = i + 1) mem[i] = 8'h00;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      wb(0, 7'h03, 8'h00, 1);
      wb(0, 7'h09, 8'h00, 1);
      wb(1, 7'h03, 8'hFF, 1);
      wb(1, 7'h09, 8'hA5, 0);
      wb(0, 7'h03, 8'h00, 1);
      wb(0, 7'h09, 8'h00, 1);
      $display("test registers done");
      for (i = 0; i < 48; i = i + 1) begin
         rv = $random(seed);
         x = {1'b1, rv[5:0]};
         wb(1, x, i % 3 == 0 ? {8{i[1]}} : rv[15:8], 1);
         wb(1, 7'h09, rv[23:16], 1);
         wb(1, 7'h03, rv[31:24], 1);
         exe({ops[i % 12], rv[6], x});
         exe({ops[(i + 7) % 12], 1'b1, x});
         wb(0, x, 8'h00, 1);
      end
      $display("test operations done");
      wb(1, 7'h09, 8'h5A, 1);
      for (i = 0; i < 4; i = i + 1) exe({12'h040, i[1:0]});
      exe(14'h0044);
      exe(14'h3F80);
      exe({7'h03, 7'h7F});
      wb(0, 7'h7F, 8'h00, 1);
      $display("test clears done");
      repeat (2) @(posedge sys_clk);
      wrap_up;
   end
endmodule
